// File: rtl/ahb_reg_port.sv
// AHB-Lite slave front end: zero-wait writes, one-wait reads
module ahb_reg_port
(
   input wire logic i_ref_clk,          // System clock
   input wire logic i_rst,              // Sync reset, high
   input wire logic i_hsel,             // Slave select
   input wire logic [31:0] i_haddr,     // Byte address
   input wire logic [1:0] i_htrans,     // Transfer type
   input wire logic i_hwrite,           // Write when high
   input wire logic i_hready,           // Bus ready
   input wire logic [31:0] i_hwdata,    // Write data
   output logic o_hreadyout,            // Slave ready
   output logic [31:0] o_hrdata,        // Read data
   regbus_if.port bus                   // Register side
);

   ata_tf_pkg::ahb_state_t state_reg, state_next;
   logic [ata_tf_pkg::IDX_W-1:0] idx_reg, idx_next;
   logic hit_reg, hit_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic accept;

   ////////////////////////////////////////////////////////////////////////////
   // Read takes a wait state so a read never samples a register mid-write
   assign accept = i_hsel && i_htrans[1] && i_hready;

   always_comb
   begin
      state_next = state_reg;
      idx_next = idx_reg;
      hit_next = hit_reg;
      hrdata_next = hrdata_reg;
      unique case (state_reg)
         ata_tf_pkg::ST_IDLE, ata_tf_pkg::ST_WRITE, ata_tf_pkg::ST_RD_OUT:
         begin
            state_next = ata_tf_pkg::ST_IDLE;
            if (accept)
            begin
               state_next = i_hwrite ? ata_tf_pkg::ST_WRITE : ata_tf_pkg::ST_RD_WAIT;
               idx_next = i_haddr[ata_tf_pkg::IDX_W+1:2];
               hit_next = (i_haddr & ata_tf_pkg::ADDR_SPAN_MASK) == ata_tf_pkg::RDATA_ZERO;
            end
         end
         ata_tf_pkg::ST_RD_WAIT:
         begin
            state_next = ata_tf_pkg::ST_RD_OUT;
            hrdata_next = hit_reg ? {24'h00_0000, bus.rdata} : ata_tf_pkg::RDATA_ZERO;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         state_reg <= ata_tf_pkg::ST_IDLE;
         idx_reg <= '0;
         hit_reg <= 1'b0;
         hrdata_reg <= ata_tf_pkg::RDATA_ZERO;
      end
      else
      begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         hit_reg <= hit_next;
         hrdata_reg <= hrdata_next;
      end
   end

   assign o_hreadyout = (state_reg != ata_tf_pkg::ST_RD_WAIT);
   assign o_hrdata = hrdata_reg;
   assign bus.wr_en = (state_reg == ata_tf_pkg::ST_WRITE) && hit_reg;
   assign bus.rd_en = (state_reg == ata_tf_pkg::ST_RD_WAIT) && hit_reg;
   assign bus.idx = idx_reg;
   assign bus.wdata = i_hwdata[7:0];

endmodule

// File: rtl/ata_addr_view.sv
// Splits cylinder high and drive/head into CHS or LBA address fields
module ata_addr_view
(
   input wire logic [7:0] i_cyl_high,   // Cylinder high byte
   input wire logic [7:0] i_drive_head, // Drive/head byte
   output logic o_lba_mode,             // LBA addressing
   output logic [7:0] o_cyl_high,       // CHS cylinder high, else 0
   output logic [3:0] o_head,           // CHS head, else 0
   output logic [11:0] o_lba_hi         // LBA bits 27..16, else 0
);

   assign o_lba_mode = i_drive_head[ata_tf_pkg::DH_LBA_BIT]; // [RULE6]

   always_comb
   begin
      o_cyl_high = 8'h00;
      o_head = 4'h0;
      o_lba_hi = 12'h000;
      if (o_lba_mode)
      begin
         o_lba_hi = {i_drive_head[ata_tf_pkg::DH_HEAD_MSB:0], i_cyl_high}; // [RULE3] [RULE11]
      end
      else
      begin
         o_cyl_high = i_cyl_high; // [RULE1]
         o_head = i_drive_head[ata_tf_pkg::DH_HEAD_MSB:0]; // [RULE11]
      end
   end

endmodule

// File: rtl/ata_taskfile_regs.sv
// Cylinder high and drive/head task-file registers behind an AHB-Lite slave
//
// The register addresses and the AHB-Lite slave port were decided locally.
module ata_taskfile_regs
#(
   parameter bit SOCKET_COPY_PRESENT = 1'b1
)
(
   input wire logic i_ref_clk,          // 40 MHz clock
   input wire logic i_rst,              // Sync reset, high
   input wire logic i_hsel,             // AHB select
   input wire logic [31:0] i_haddr,     // AHB address
   input wire logic [1:0] i_htrans,     // AHB transfer type
   input wire logic i_hwrite,           // AHB write
   input wire logic [2:0] i_hsize,      // AHB size, word only
   input wire logic i_hready,           // AHB ready in
   input wire logic [31:0] i_hwdata,    // AHB write data
   output logic o_hreadyout,            // AHB ready out
   output logic o_hresp,                // AHB response, OKAY
   output logic [31:0] o_hrdata,        // AHB read data
   input wire logic i_cmd_done,         // Command complete pulse
   input wire logic [7:0] i_final_cyl,  // Final cylinder high or LBA 23..16
   input wire logic [3:0] i_final_head, // Final head or LBA 27..24
   output logic o_cmd_start,            // Command start pulse
   output logic o_busy,                 // Command in progress
   output logic o_selected,             // Device bit matches card
   output logic o_card_number,          // Own card number
   output logic o_lba_mode,             // Latched LBA mode
   output logic [7:0] o_cyl_high,       // Latched CHS cylinder high
   output logic [3:0] o_head,           // Latched CHS head
   output logic [11:0] o_lba_hi         // Latched LBA bits 27..16
);

   regbus_if bus();

   logic [7:0] cyl_reg, cyl_next;
   logic [7:0] dh_reg, dh_next;
   logic [7:0] sc_reg, sc_next;
   logic busy_reg, busy_next;
   logic mode_reg, mode_next;
   logic [7:0] scyl_reg, scyl_next;
   logic [3:0] shead_reg, shead_next;
   logic [11:0] slba_reg, slba_next;
   logic view_mode;
   logic [7:0] view_cyl;
   logic [3:0] view_head;
   logic [11:0] view_lba;
   logic card_num;
   logic selected;
   logic wr_cyl, wr_dh, wr_sc, cmd_start;

   ////////////////////////////////////////////////////////////////////////////
   ahb_reg_port u_port
   (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_hsel(i_hsel),
      .i_haddr(i_haddr),
      .i_htrans(i_htrans),
      .i_hwrite(i_hwrite),
      .i_hready(i_hready),
      .i_hwdata(i_hwdata),
      .o_hreadyout(o_hreadyout),
      .o_hrdata(o_hrdata),
      .bus(bus.port)
   );

   ata_addr_view u_view
   (
      .i_cyl_high(cyl_reg),
      .i_drive_head(dh_reg),
      .o_lba_mode(view_mode),
      .o_cyl_high(view_cyl),
      .o_head(view_head),
      .o_lba_hi(view_lba)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Without the socket-and-copy register the card is always card 0
   assign card_num = SOCKET_COPY_PRESENT ? sc_reg[ata_tf_pkg::COPY_LSB] : 1'b0; // [RULE9]
   assign selected = (dh_reg[ata_tf_pkg::DH_DEV_BIT] == card_num); // [RULE5] [RULE8]

   // Drive/head writes always land, or a deselected card could only be reselected through the copy field
   assign wr_dh = bus.wr_en && (bus.idx == ata_tf_pkg::IDX_DRIVE_HEAD);
   assign wr_cyl = bus.wr_en && (bus.idx == ata_tf_pkg::IDX_CYL_HIGH) && selected; // [RULE12]
   assign wr_sc = bus.wr_en && (bus.idx == ata_tf_pkg::IDX_SOCKET_COPY) && SOCKET_COPY_PRESENT;
   assign cmd_start = bus.wr_en && (bus.idx == ata_tf_pkg::IDX_CMD_STATUS) && selected; // [RULE12]

   always_comb
   begin
      bus.rdata = 8'h00;
      unique case (bus.idx)
         ata_tf_pkg::IDX_CYL_HIGH:
         begin
            if (selected)
            begin
               bus.rdata = cyl_reg; // [RULE2] [RULE4] [RULE12]
            end
         end
         ata_tf_pkg::IDX_DRIVE_HEAD:
         begin
            bus.rdata = dh_reg | ata_tf_pkg::DH_ONES_MASK; // [RULE7]
         end
         ata_tf_pkg::IDX_SOCKET_COPY:
         begin
            bus.rdata = SOCKET_COPY_PRESENT ? sc_reg : 8'h00;
         end
         ata_tf_pkg::IDX_CMD_STATUS:
         begin
            if (selected)
            begin
               bus.rdata[ata_tf_pkg::STAT_BUSY_BIT] = busy_reg;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Completion beats a host write in the same cycle: final address must stick
   always_comb
   begin
      cyl_next = cyl_reg;
      dh_next = dh_reg;
      sc_next = sc_reg;
      busy_next = busy_reg;
      mode_next = mode_reg;
      scyl_next = scyl_reg;
      shead_next = shead_reg;
      slba_next = slba_reg;
      if (wr_cyl)
      begin
         cyl_next = bus.wdata; // [RULE1] [RULE3]
      end
      if (wr_dh)
      begin
         dh_next = bus.wdata | ata_tf_pkg::DH_ONES_MASK; // [RULE5] [RULE7]
      end
      if (wr_sc)
      begin
         sc_next = bus.wdata;
      end
      if (i_cmd_done)
      begin
         busy_next = 1'b0;
         cyl_next = i_final_cyl; // [RULE2] [RULE4]
         dh_next[ata_tf_pkg::DH_HEAD_MSB:0] = i_final_head; // [RULE11]
      end
      if (cmd_start)
      begin
         busy_next = 1'b1;
         mode_next = view_mode; // [RULE6]
         scyl_next = view_cyl; // [RULE1]
         shead_next = view_head; // [RULE11]
         slba_next = view_lba; // [RULE3] [RULE11]
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         cyl_reg <= ata_tf_pkg::CYL_RESET;
         dh_reg <= ata_tf_pkg::DH_RESET;
         sc_reg <= ata_tf_pkg::SC_RESET;
         busy_reg <= 1'b0;
         mode_reg <= 1'b0;
         scyl_reg <= 8'h00;
         shead_reg <= 4'h0;
         slba_reg <= 12'h000;
      end
      else
      begin
         cyl_reg <= cyl_next;
         dh_reg <= dh_next;
         sc_reg <= sc_next;
         busy_reg <= busy_next;
         mode_reg <= mode_next;
         scyl_reg <= scyl_next;
         shead_reg <= shead_next;
         slba_reg <= slba_next;
      end
   end

   assign o_hresp = 1'b0;
   assign o_cmd_start = cmd_start;
   assign o_busy = busy_reg;
   assign o_selected = selected;
   assign o_card_number = card_num;
   assign o_lba_mode = mode_reg;
   assign o_cyl_high = scyl_reg;
   assign o_head = shead_reg;
   assign o_lba_hi = slba_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   chs_cyl_latch_a: assert property ((cmd_start && !dh_reg[ata_tf_pkg::DH_LBA_BIT]) |=> // [RULE1]
      (o_cyl_high == $past(cyl_reg)) && (o_lba_hi == 12'h000))
      else $error("CHS cylinder high not latched at command start");

   // A start in the same cycle keeps busy set, so busy is only required low without one
   final_cyl_a: assert property (i_cmd_done |=> (cyl_reg == $past(i_final_cyl)) && (!o_busy || $past(cmd_start))) // [RULE2]
      else $error("final cylinder high not held after completion");

   lba_mid_a: assert property ((cmd_start && dh_reg[ata_tf_pkg::DH_LBA_BIT]) |=> // [RULE3]
      (o_lba_hi[7:0] == $past(cyl_reg)) && (o_cyl_high == 8'h00))
      else $error("LBA bits 23..16 not taken from cylinder high");

   final_top_a: assert property (i_cmd_done |=> dh_reg[ata_tf_pkg::DH_HEAD_MSB:0] == $past(i_final_head)) // [RULE4]
      else $error("final high address bits not held after completion");

   select_flag_a: assert property (wr_dh |=> o_selected == ($past(bus.wdata[ata_tf_pkg::DH_DEV_BIT]) == o_card_number)) // [RULE5]
      else $error("selection does not follow device bit");

   mode_latch_a: assert property (cmd_start |=> (o_lba_mode == $past(dh_reg[ata_tf_pkg::DH_LBA_BIT])) && o_busy) // [RULE6]
      else $error("addressing mode not latched from bit 6");

   ones_read_a: assert property ((bus.rd_en && bus.idx == ata_tf_pkg::IDX_DRIVE_HEAD) |=> // [RULE7]
      o_hrdata[7] && o_hrdata[5])
      else $error("drive/head bits 7 and 5 not read as ones");

   card_copy_a: assert property (wr_sc |=> o_card_number == $past(bus.wdata[ata_tf_pkg::COPY_LSB])) // [RULE9]
      else $error("card number not taken from copy field");

   head_latch_a: assert property ((cmd_start && !dh_reg[ata_tf_pkg::DH_LBA_BIT]) |=> // [RULE11]
      o_head == $past(dh_reg[ata_tf_pkg::DH_HEAD_MSB:0]))
      else $error("head number not latched from bits 3..0");

   deselect_guard_a: assert property ((bus.wr_en && bus.idx == ata_tf_pkg::IDX_CYL_HIGH && !selected // [RULE12]
      && !i_cmd_done) |=> $stable(cyl_reg))
      else $error("cylinder high written while deselected");

   deselect_read_a: assert property ((bus.rd_en && bus.idx == ata_tf_pkg::IDX_CYL_HIGH && !selected) // [RULE12]
      |=> o_hrdata == 32'h0000_0000)
      else $error("cylinder high answered while deselected");

   chs_cmd_c: cover property (cmd_start && !dh_reg[ata_tf_pkg::DH_LBA_BIT] ##[1:20] i_cmd_done);
   lba_cmd_c: cover property (cmd_start && dh_reg[ata_tf_pkg::DH_LBA_BIT] ##[1:20] i_cmd_done);
   card1_sel_c: cover property (selected && card_num);
   deselect_wr_c: cover property (bus.wr_en && !selected);

endmodule

// File: rtl/ata_tf_pkg.sv
// Constants for the cylinder-high and drive/head task-file register bank
// How it works
// (RULE1) In CHS mode the cylinder high byte written by the host is the upper cylinder byte used by the next command.
// (RULE2) When a CHS command completes, the final upper cylinder byte is left in cylinder high for readback.
// (RULE3) In LBA mode the cylinder high byte is taken as start block address bits 23 to 16.
// (RULE4) When an LBA command completes, final block address bits 23 to 16 are left in cylinder high.
// (RULE5) The drive/head register tells which of the two devices sharing the registers is selected.
// (RULE6) Drive/head bit 6 picks CHS (0) or LBA (1) and the address registers are read that way.
// (RULE7) The host writes ones to drive/head bits 7 and 5, and these bits always read back as ones.
// (RULE8) Drive/head bit 4 is the selected device number, 0 for card 0 and 1 for card 1.
// (RULE9) The card takes its own card number from the copy field of its socket-and-copy register when that exists.
// (RULE10) Without that register, or without paired-card support, the host keeps the device bit at zero.
// (RULE11) Drive/head bits 3 to 0 are head bits 3 to 0 in CHS mode and block address bits 27 to 24 in LBA mode.
// (RULE12) Task-file accesses other than drive/head are answered only while the device bit matches the card number.
package ata_tf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int IDX_W = 2;
   localparam logic [31:0] ADDR_SPAN_MASK = 32'hFFFF_FFF0;
   localparam logic [IDX_W-1:0] IDX_CYL_HIGH = 2'h0;    // byte 0x00
   localparam logic [IDX_W-1:0] IDX_DRIVE_HEAD = 2'h1;  // byte 0x04
   localparam logic [IDX_W-1:0] IDX_SOCKET_COPY = 2'h2; // byte 0x08
   localparam logic [IDX_W-1:0] IDX_CMD_STATUS = 2'h3;  // byte 0x0C

   ////////////////////////////////////////////////////////////////////////////
   localparam int DH_LBA_BIT = 6;
   localparam int DH_DEV_BIT = 4;
   localparam int DH_HEAD_MSB = 3;
   localparam logic [7:0] DH_ONES_MASK = 8'hA0;
   localparam logic [7:0] DH_RESET = 8'hA0;
   localparam logic [7:0] CYL_RESET = 8'h00;
   localparam logic [7:0] SC_RESET = 8'h00;
   localparam int COPY_LSB = 4;
   localparam int STAT_BUSY_BIT = 0;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WRITE,
      ST_RD_WAIT,
      ST_RD_OUT
   } ahb_state_t;

endpackage

// File: rtl/regbus_if.sv
// Internal register access carrier between the bus port and the register bank
interface regbus_if;
   logic wr_en;
   logic rd_en;
   logic [ata_tf_pkg::IDX_W-1:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport port
   (
      output wr_en,
      output rd_en,
      output idx,
      output wdata,
      input rdata
   );

   modport bank
   (
      input wr_en,
      input rd_en,
      input idx,
      input wdata,
      output rdata
   );
endinterface

// File: tb/host_model.sv
// Host adapter model issuing single-word AHB-Lite transfers to the task file
module host_model
(
   input wire logic i_ref_clk,       // Bus clock
   input wire logic i_hready,        // Slave ready
   input wire logic [31:0] i_hrdata, // Read data
   output logic o_hsel,              // Select
   output logic [31:0] o_haddr,      // Address
   output logic [1:0] o_htrans,      // Transfer type
   output logic o_hwrite,            // Write
   output logic [31:0] o_hwdata      // Write data
);
   timeunit 1ns;
   timeprecision 100ps;
   event rd_ev;
   logic [31:0] rd_data;
   logic [31:0] last_rdata;
   bit tmo;

   initial
   begin
      o_hsel = 1'b0;
      o_haddr = 32'h0000_0000;
      o_htrans = 2'h0;
      o_hwrite = 1'b0;
      o_hwdata = 32'hFFFF_FFFF;
      tmo = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ready is a registered level, so its value at the falling edge is the one sampled
   task automatic wait_ready();
      int n;
      logic ok;
      n = 0;
      ok = 1'b0;
      while (!ok && n < 50)
      begin
         @(negedge i_ref_clk);
         ok = (i_hready === 1'b1);
         last_rdata = i_hrdata;
         @(posedge i_ref_clk);
         n++;
      end
      if (!ok)
         tmo = 1'b1;
   endtask

   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      o_hsel <= 1'b1;
      o_haddr <= a;
      o_hwrite <= w;
      o_htrans <= 2'h2;
      wait_ready();
      o_htrans <= 2'h0;
      o_hsel <= 1'b0;
      o_hwdata <= w ? d : ~d;
      wait_ready();
      // Released data bus shows the inverse of d, never the written value
      o_hwdata <= ~d;
      if (!w)
      begin
         rd_data = last_rdata;
         -> rd_ev;
      end
   endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the cylinder-high and drive/head register bank
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic hsel, hwrite, hreadyout, hresp, cmd_start, busy, selected, card_number, lba_mode;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic cmd_done = 1'b0;
   logic [7:0] final_cyl = 8'h00;
   logic [3:0] final_head = 4'h0;
   logic [7:0] cyl_high;
   logic [3:0] head;
   logic [11:0] lba_hi;
   logic [31:0] exp_q[$];
   int mismatches = 0;
   int checked = 0;
   int starts = 0;

   always #12.5 i_ref_clk = ~i_ref_clk;

   // Start is a one-cycle combinational pulse; mid-cycle sampling avoids the edge race
   always @(negedge i_ref_clk)
      if (cmd_start === 1'b1)
         starts++;

   host_model u_host (.i_ref_clk(i_ref_clk), .i_hready(hreadyout), .i_hrdata(hrdata), .o_hsel(hsel),
      .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hwdata(hwdata));

   ata_taskfile_regs uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hreadyout), .i_hwdata(hwdata),
      .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata), .i_cmd_done(cmd_done),
      .i_final_cyl(final_cyl), .i_final_head(final_head), .o_cmd_start(cmd_start), .o_busy(busy),
      .o_selected(selected), .o_card_number(card_number), .o_lba_mode(lba_mode),
      .o_cyl_high(cyl_high), .o_head(head), .o_lba_hi(lba_hi));

   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (mismatches == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
      u_host.xfer(a, w, {24'h00_0000, d});
      if (u_host.tmo)
      begin
         mismatches++;
         $display("[FAIL] %0t bus wait timed out", $time);
         close_out();
      end
   endtask

   task automatic rd(input logic [31:0] a, input logic [7:0] e);
      exp_q.push_back({24'h00_0000, e});
      xfer(a, 1'b0, 8'h00);
   endtask

   // Watcher pairs each completed read with the oldest expectation
   always @(u_host.rd_ev)
   begin
      checked++;
      if (exp_q.size() == 0 || u_host.rd_data !== exp_q.pop_front())
      begin
         mismatches++;
         $display("[FAIL] %0t read data", $time);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One command: load start address, start, check latched view, complete, read back
   task automatic run_cmd(input logic [7:0] dh, input logic [7:0] cy, input logic [7:0] fc,
                          input logic [3:0] fh);
      logic lba;
      lba = dh[6];
      xfer(32'h0000_0004, 1'b1, dh);
      xfer(32'h0000_0000, 1'b1, cy);
      xfer(32'h0000_000C, 1'b1, 8'h20);
      #1;
      chk({31'h0, lba_mode}, {31'h0, lba}, "mode latch");
      chk({24'h0, cyl_high}, lba ? 32'h0 : {24'h0, cy}, "chs cylinder");
      chk({28'h0, head}, lba ? 32'h0 : {28'h0, dh[3:0]}, "chs head");
      chk({20'h0, lba_hi}, lba ? {20'h0, dh[3:0], cy} : 32'h0, "lba upper");
      chk({31'h0, busy}, 32'h1, "busy");
      rd(32'h0000_000C, 8'h01);
      @(posedge i_ref_clk);
      cmd_done <= 1'b1;
      final_cyl <= fc;
      final_head <= fh;
      @(posedge i_ref_clk);
      cmd_done <= 1'b0;
      final_cyl <= ~fc;
      final_head <= ~fh;
      rd(32'h0000_0000, fc);
      rd(32'h0000_0004, {dh[7:4] | 4'hA, fh});
      rd(32'h0000_000C, 8'h00);
   endtask

   initial
   begin
      logic [7:0] dh, cy, fc;
      logic [3:0] fh;
      void'($urandom(32'h28C2));
      repeat (5) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(posedge i_ref_clk);
      chk({31'h0, selected}, 32'h1, "reset select");
      chk({31'h0, card_number}, 32'h0, "reset card");
      chk({31'h0, hresp}, 32'h0, "response");
      rd(32'h0000_0000, 8'h00);
      rd(32'h0000_0004, 8'hA0);
      rd(32'h0000_0008, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         cy = 8'($urandom);
         fc = 8'($urandom);
         fh = 4'($urandom);
         dh = {1'b1, i[0], 1'b1, 1'b0, 4'($urandom)};
         run_cmd(dh, cy, fc, fh);
      end
      // Device bit set while this card is card 0: task file goes quiet
      xfer(32'h0000_0004, 1'b1, 8'hB0);
      #1;
      chk({31'h0, selected}, 32'h0, "deselect");
      rd(32'h0000_0000, 8'h00);
      xfer(32'h0000_0000, 1'b1, 8'h55);
      xfer(32'h0000_000C, 1'b1, 8'h20);
      #1;
      chk({31'h0, busy}, 32'h0, "start while deselected");
      xfer(32'h0000_0008, 1'b1, 8'h10);
      #1;
      chk({31'h0, card_number}, 32'h1, "copy field");
      chk({31'h0, selected}, 32'h1, "reselect");
      rd(32'h0000_0000, fc);
      rd(32'h0000_0008, 8'h10);
      rd(32'h0000_0004, 8'hB0);
      rd(32'h0000_0010, 8'h00);
      xfer(32'h0000_0004, 1'b1, 8'hA0);
      #1;
      chk({31'h0, selected}, 32'h0, "card one, device zero");
      repeat (2) @(posedge i_ref_clk);
      chk(exp_q.size(), 32'h0, "reads outstanding");
      chk(starts, 32'h6, "start pulses");
      close_out();
   end
endmodule
